// ===== hdl/pdc_params.svh
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// Station number handling
`define PDC_STATION_DEFAULT 7'h64
`define PDC_SELECTOR_BUS 7'h00

// Parameter module indices and key
`define PDC_IDX_UNLOCK 8'h7E
`define PDC_IDX_STATION 8'h34
`define PDC_IDX_COMMIT 8'hB4
`define PDC_IDX_JOG_INCR 8'h10
`define PDC_IDX_JOG_PAUSE 8'h11
`define PDC_IDX_LOOP_LEN 8'h12
`define PDC_IDX_LOOP_DIR 8'h13
`define PDC_IDX_JOG_EN 8'h14
`define PDC_UNLOCK_KEY 16'h00AA

// Command word bit positions
`define PDC_CMD_MAN_UP 0
`define PDC_CMD_MAN_DOWN 1
`define PDC_CMD_ACCEPT 2
`define PDC_CMD_SET_REF 3
`define PDC_CMD_REF_VALUE 4
`define PDC_CMD_NO_LOOP 5
`define PDC_CMD_MAN_REL 6
`define PDC_CMD_RELEASE 7
`define PDC_CMD_CONFIRM 8

// Status word bit positions
`define PDC_ST_REACHED 15
`define PDC_ST_RUNNING 14
`define PDC_ST_READY 12
`define PDC_ST_HW_ERR 11
`define PDC_ST_ABORTED 10
`define PDC_ST_JOG_DOWN 9
`define PDC_ST_JOG_UP 8
`define PDC_ST_POS_ERR 4

// Parameter reset values
`define PDC_JOG_INCR_RST 16'h0010
`define PDC_JOG_PAUSE_RST 16'h0004
`define PDC_LOOP_LEN_RST 16'h0040

// Timing: jog pause unit and rotation length
`define PDC_PAUSE_UNIT_US 1000
`define PDC_CLK_MHZ 25
`define PDC_PAUSE_UNIT_CYC (`PDC_PAUSE_UNIT_US * `PDC_CLK_MHZ)
`define PDC_ROTATION_RST 32'h0000_0400

`endif

// ===== hdl/pdc_pkg.sv
package pdc_pkg;

    // Motion sequencer states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_FWD = 7'h02,
        S_REV = 7'h04,
        S_JOG_STEP = 7'h08,
        S_JOG_PAUSE = 7'h10,
        S_JOG_RUN = 7'h20,
        S_CHECK = 7'h40
    } pdc_motion_t;

    // Station number rewrite sequence
    typedef enum logic [2:0] {
        A_LOCKED = 3'h1,
        A_UNLOCKED = 3'h2,
        A_NUMBER = 3'h4
    } pdc_addr_t;

endpackage : pdc_pkg

// ===== hdl/pdc_drive_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"

module pdc_drive_control #(
    parameter int PAUSE_UNIT_CYC = `PDC_PAUSE_UNIT_CYC,
    parameter int OLD_FIRMWARE = 0
) (
    input wire logic clock,
    input wire logic reset,
    // Cyclic data from master
    input wire logic [15:0] commandFlags,
    input wire logic [31:0] targetPosition,
    input wire logic [7:0] parameterIndex,
    input wire logic [15:0] parameterDataToDevice,
    input wire logic cycleStrobe,
    // Cyclic data to master
    output logic [15:0] statusFlags,
    output logic [31:0] actualPosition,
    output logic [15:0] parameterDataFromDevice,
    output logic [7:0] readBackIndex,
    // Station number
    input wire logic [6:0] addressSelector,
    output logic [6:0] stationNumber,
    // Persistent store of station number and reference
    input wire logic [6:0] storedStation,
    input wire logic storedStationValid,
    output logic storeStationWrite,
    output logic [6:0] storeStationData,
    output logic storeRefWrite,
    output logic [31:0] storeRefData,
    output logic selfReset,
    // Jog key pins
    input wire logic jogKeyUp,
    input wire logic jogKeyDown,
    // Drive and encoder
    input wire logic internalError,
    input wire logic [31:0] encoderPosition,
    output logic motorForward,
    output logic motorReverse,
    output logic motorManualSpeed
);

    if (PAUSE_UNIT_CYC < 1) begin : gen_bad_pause
        $error("PAUSE_UNIT_CYC must be at least one");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] upSync_q;
    logic [2:0] downSync_q;
    logic jogUp_q;
    logic jogDown_q;

    // Three stages, change accepted when last two agree
    always_ff @(posedge clock) begin
        if (reset) begin
            upSync_q <= 3'h0;
            downSync_q <= 3'h0;
            jogUp_q <= 1'b0;
            jogDown_q <= 1'b0;
        end else begin
            upSync_q <= {upSync_q[1:0], jogKeyUp};
            downSync_q <= {downSync_q[1:0], jogKeyDown};
            if (upSync_q[1] == upSync_q[2]) begin
                jogUp_q <= upSync_q[2];
            end
            if (downSync_q[1] == downSync_q[2]) begin
                jogDown_q <= downSync_q[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Parameters and station number rewrite
    // ----------------------------------------------------------------
    pdc_pkg::pdc_addr_t addrState_q;
    logic [6:0] newStation_q;
    logic [15:0] jogIncr_q;
    logic [15:0] jogPause_q;
    logic [15:0] loopLen_q;
    logic loopReverse_q;
    logic jogParamEn_q;
    logic unlockErr_q;
    logic [15:0] paramOut_q;
    logic [7:0] echo_q;
    logic [7:0] lastIndex_q;
    logic newIndex;

    assign newIndex = cycleStrobe && (parameterIndex != lastIndex_q);

    // Sequence unlock, number, commit; plain parameters otherwise
    always_ff @(posedge clock) begin
        if (reset) begin
            addrState_q <= pdc_pkg::A_LOCKED;
            newStation_q <= 7'h00;
            jogIncr_q <= `PDC_JOG_INCR_RST;
            jogPause_q <= `PDC_JOG_PAUSE_RST;
            loopLen_q <= `PDC_LOOP_LEN_RST;
            loopReverse_q <= 1'b0;
            jogParamEn_q <= 1'b0;
            unlockErr_q <= 1'b0;
            paramOut_q <= 16'h0000;
            echo_q <= 8'h00;
            lastIndex_q <= 8'h00;
            storeStationWrite <= 1'b0;
            storeStationData <= 7'h00;
            selfReset <= 1'b0;
        end else begin
            storeStationWrite <= 1'b0;
            selfReset <= 1'b0;
            // Release low acknowledges unlock error; a new unlock wins
            if (!commandFlags[`PDC_CMD_RELEASE]) begin
                unlockErr_q <= 1'b0;
            end
            if (cycleStrobe) begin
                lastIndex_q <= parameterIndex;
                echo_q <= parameterIndex;
                unique case (parameterIndex)
                    `PDC_IDX_UNLOCK: begin
                        if (parameterDataToDevice == `PDC_UNLOCK_KEY) begin
                            addrState_q <= pdc_pkg::A_UNLOCKED;
                            unlockErr_q <= 1'b1;
                        end
                        paramOut_q <= 16'h0000;
                    end
                    `PDC_IDX_STATION: begin
                        if (addrState_q != pdc_pkg::A_LOCKED) begin
                            newStation_q <= parameterDataToDevice[6:0];
                            addrState_q <= pdc_pkg::A_NUMBER;
                        end
                        paramOut_q <= 16'h0000;
                    end
                    `PDC_IDX_COMMIT: begin
                        paramOut_q <= 16'h0000;
                        if (newIndex && addrState_q == pdc_pkg::A_NUMBER
                                && parameterDataToDevice[6:0] == newStation_q) begin
                            storeStationWrite <= 1'b1;
                            storeStationData <= newStation_q;
                            selfReset <= 1'b1;
                            addrState_q <= pdc_pkg::A_LOCKED;
                        end
                    end
                    `PDC_IDX_JOG_INCR: begin
                        jogIncr_q <= parameterDataToDevice;
                        paramOut_q <= jogIncr_q;
                    end
                    `PDC_IDX_JOG_PAUSE: begin
                        jogPause_q <= parameterDataToDevice;
                        paramOut_q <= jogPause_q;
                    end
                    `PDC_IDX_LOOP_LEN: begin
                        loopLen_q <= parameterDataToDevice;
                        paramOut_q <= loopLen_q;
                    end
                    `PDC_IDX_LOOP_DIR: begin
                        loopReverse_q <= parameterDataToDevice[0];
                        paramOut_q <= {15'h0000, loopReverse_q};
                    end
                    `PDC_IDX_JOG_EN: begin
                        jogParamEn_q <= parameterDataToDevice[0];
                        paramOut_q <= {15'h0000, jogParamEn_q};
                    end
                    default: begin
                        paramOut_q <= 16'h0000;
                    end
                endcase
            end
        end
    end

    assign parameterDataFromDevice = paramOut_q;
    assign readBackIndex = echo_q;

    // Station number: selector wins unless at zero
    always_ff @(posedge clock) begin
        if (reset) begin
            stationNumber <= `PDC_STATION_DEFAULT;
        end else if (addressSelector != `PDC_SELECTOR_BUS) begin
            stationNumber <= addressSelector;
        end else if (storedStationValid) begin
            stationNumber <= storedStation;
        end else begin
            stationNumber <= `PDC_STATION_DEFAULT;
        end
    end

    // ----------------------------------------------------------------
    // Motion sequencer
    // ----------------------------------------------------------------
    pdc_pkg::pdc_motion_t state_q;
    logic signed [31:0] pos_q;
    logic signed [31:0] goal_q;
    logic signed [31:0] final_q;
    logic [31:0] pauseCnt_q;
    logic [15:0] pauseUnits_q;
    logic jogDirUp_q;
    logic lastRunRev_q;
    logic posErr_q;
    logic hwErr_q;
    logic aborted_q;
    logic reached_q;
    logic released;
    logic accept;
    logic jogEnabled;
    logic jogUpReq;
    logic jogDownReq;
    logic signed [31:0] target;
    logic signed [31:0] loop32;
    logic signed [31:0] stepDir;

    assign released = commandFlags[`PDC_CMD_RELEASE];
    assign accept = commandFlags[`PDC_CMD_ACCEPT];
    assign jogEnabled = (jogParamEn_q || commandFlags[`PDC_CMD_MAN_REL])
                        && released && !accept;
    // Master jog or direct keys
    assign jogUpReq = (released && !accept && commandFlags[`PDC_CMD_MAN_UP])
                      || (jogEnabled && jogUp_q);
    assign jogDownReq = (released && !accept && commandFlags[`PDC_CMD_MAN_DOWN])
                        || (jogEnabled && jogDown_q);
    assign target = $signed(targetPosition);
    assign loop32 = $signed({16'h0000, loopLen_q});
    assign stepDir = jogDirUp_q ? 32'sh0000_0001 : -32'sh0000_0001;

    // Sequencer: positioning runs, jog steps, end check
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= pdc_pkg::S_IDLE;
            pos_q <= 32'sh0000_0000;
            goal_q <= 32'sh0000_0000;
            final_q <= 32'sh0000_0000;
            pauseCnt_q <= 32'h0000_0000;
            pauseUnits_q <= 16'h0000;
            jogDirUp_q <= 1'b0;
            lastRunRev_q <= 1'b0;
            posErr_q <= 1'b0;
            hwErr_q <= 1'b0;
            aborted_q <= 1'b0;
            reached_q <= 1'b0;
            storeRefWrite <= 1'b0;
            storeRefData <= 32'h0000_0000;
        end else begin
            storeRefWrite <= 1'b0;
            if (internalError) begin
                hwErr_q <= 1'b1;
            end else if (!released) begin
                hwErr_q <= 1'b0;
            end
            if ((internalError || !released) && state_q != pdc_pkg::S_IDLE) begin
                state_q <= pdc_pkg::S_IDLE;
                aborted_q <= 1'b1;
            end else begin
                unique case (state_q)
                    pdc_pkg::S_IDLE: begin
                        if (commandFlags[`PDC_CMD_SET_REF]) begin
                            pos_q <= OLD_FIRMWARE != 0 ? 32'sh0000_0000 : target;
                            storeRefWrite <= 1'b1;
                            storeRefData <= OLD_FIRMWARE != 0 ? 32'h0000_0000 : targetPosition;
                        end else if (released && accept && !hwErr_q
                                && target != pos_q) begin
                            posErr_q <= 1'b0;
                            aborted_q <= 1'b0;
                            reached_q <= 1'b0;
                            final_q <= target;
                            if (commandFlags[`PDC_CMD_NO_LOOP] || loopLen_q == 16'h0000) begin
                                goal_q <= target;
                                state_q <= target > pos_q ? pdc_pkg::S_FWD : pdc_pkg::S_REV;
                            end else if (loopReverse_q) begin
                                goal_q <= target + loop32;
                                state_q <= pdc_pkg::S_FWD;
                            end else if (target > pos_q && !lastRunRev_q) begin
                                goal_q <= target;
                                state_q <= pdc_pkg::S_FWD;
                            end else if (target > pos_q) begin
                                goal_q <= (target - loop32 < pos_q)
                                    ? pos_q - $signed(`PDC_ROTATION_RST) : target - loop32;
                                state_q <= pdc_pkg::S_REV;
                            end else begin
                                goal_q <= target - loop32;
                                state_q <= pdc_pkg::S_REV;
                            end
                        end else if (jogUpReq || jogDownReq) begin
                            jogDirUp_q <= jogUpReq;
                            goal_q <= pos_q + (jogUpReq ? $signed({16'h0000, jogIncr_q})
                                               : -$signed({16'h0000, jogIncr_q}));
                            state_q <= pdc_pkg::S_JOG_STEP;
                        end
                    end
                    pdc_pkg::S_FWD: begin
                        lastRunRev_q <= 1'b0;
                        if (pos_q < goal_q) begin
                            pos_q <= pos_q + 32'sh0000_0001;
                        end else if (goal_q != final_q) begin
                            goal_q <= final_q;
                            state_q <= final_q > pos_q ? pdc_pkg::S_FWD : pdc_pkg::S_REV;
                        end else begin
                            state_q <= pdc_pkg::S_CHECK;
                        end
                    end
                    pdc_pkg::S_REV: begin
                        if (pos_q > goal_q) begin
                            pos_q <= pos_q - 32'sh0000_0001;
                        end else if (goal_q != final_q) begin
                            goal_q <= final_q; // Forward approach after overshoot
                            state_q <= pdc_pkg::S_FWD;
                        end else begin
                            lastRunRev_q <= 1'b1;
                            state_q <= pdc_pkg::S_CHECK;
                        end
                    end
                    pdc_pkg::S_CHECK: begin
                        posErr_q <= $signed(encoderPosition) != final_q;
                        reached_q <= 1'b1;
                        state_q <= pdc_pkg::S_IDLE;
                    end
                    pdc_pkg::S_JOG_STEP: begin
                        if (pos_q != goal_q) begin
                            pos_q <= pos_q + stepDir;
                        end else begin
                            pauseCnt_q <= 32'h0000_0000;
                            pauseUnits_q <= 16'h0000;
                            state_q <= pdc_pkg::S_JOG_PAUSE;
                        end
                    end
                    pdc_pkg::S_JOG_PAUSE: begin
                        if (!(jogDirUp_q ? jogUpReq : jogDownReq)) begin
                            state_q <= pdc_pkg::S_IDLE;
                        end else if (pauseCnt_q == 32'(PAUSE_UNIT_CYC - 1)) begin
                            pauseCnt_q <= 32'h0000_0000;
                            pauseUnits_q <= pauseUnits_q + 16'h0001;
                            // Zero pause waits for key release only
                            if (jogPause_q != 16'h0000
                                    && pauseUnits_q + 16'h0001 >= jogPause_q) begin
                                state_q <= pdc_pkg::S_JOG_RUN;
                            end
                        end else begin
                            pauseCnt_q <= pauseCnt_q + 32'h0000_0001;
                        end
                    end
                    pdc_pkg::S_JOG_RUN: begin
                        // Stop on release or a second key
                        if (!(jogDirUp_q ? jogUpReq : jogDownReq)
                                || (jogUpReq && jogDownReq)) begin
                            state_q <= pdc_pkg::S_IDLE;
                        end else begin
                            pos_q <= pos_q + stepDir;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs to drive and master
    // ----------------------------------------------------------------
    logic running;

    assign running = state_q != pdc_pkg::S_IDLE && state_q != pdc_pkg::S_CHECK
                     && state_q != pdc_pkg::S_JOG_PAUSE;

    // Registered motor commands and status word
    always_ff @(posedge clock) begin
        if (reset) begin
            motorForward <= 1'b0;
            motorReverse <= 1'b0;
            motorManualSpeed <= 1'b0;
            statusFlags <= 16'h0000;
            actualPosition <= 32'h0000_0000;
        end else begin
            motorForward <= running && (state_q == pdc_pkg::S_FWD
                            || (state_q != pdc_pkg::S_REV && jogDirUp_q));
            motorReverse <= running && (state_q == pdc_pkg::S_REV
                            || (state_q != pdc_pkg::S_FWD && !jogDirUp_q));
            motorManualSpeed <= state_q == pdc_pkg::S_JOG_RUN;
            actualPosition <= pos_q;
            statusFlags <= 16'h0000;
            statusFlags[`PDC_ST_REACHED] <= reached_q;
            statusFlags[`PDC_ST_RUNNING] <= running;
            statusFlags[`PDC_ST_READY] <= !hwErr_q && !unlockErr_q;
            statusFlags[`PDC_ST_HW_ERR] <= hwErr_q || unlockErr_q;
            statusFlags[`PDC_ST_ABORTED] <= aborted_q;
            statusFlags[`PDC_ST_JOG_DOWN] <= jogDown_q;
            statusFlags[`PDC_ST_JOG_UP] <= jogUp_q;
            statusFlags[`PDC_ST_POS_ERR] <= posErr_q;
        end
    end

endmodule : pdc_drive_control
`default_nettype wire

// ===== test/pdc_drive_control_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"
module pdc_drive_control_props (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] commandFlags,
    input wire logic [7:0] parameterIndex,
    input wire logic [15:0] parameterDataToDevice,
    input wire logic cycleStrobe,
    input wire logic [15:0] statusFlags,
    input wire logic [7:0] readBackIndex,
    input wire logic [6:0] addressSelector,
    input wire logic [6:0] stationNumber,
    input wire logic storedStationValid,
    input wire logic storeStationWrite,
    input wire logic [6:0] storeStationData,
    input wire logic selfReset,
    input wire logic jogKeyUp,
    input wire logic internalError,
    input wire logic motorForward,
    input wire logic motorReverse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Station number and parameter module
    chk_default_station: assert property ($fell(reset) && addressSelector == 7'h00
        && !storedStationValid |-> stationNumber == `PDC_STATION_DEFAULT) else $error("bad default");
    chk_selector_wins: assert property (($stable(addressSelector) && addressSelector != 7'h00)
        [*3] |-> stationNumber == addressSelector) else $error("selector ignored");
    chk_index_echo: assert property (cycleStrobe |=>
        readBackIndex == $past(parameterIndex)) else $error("index echo wrong");
    chk_unlock_flag: assert property (cycleStrobe && parameterIndex == `PDC_IDX_UNLOCK
        && parameterDataToDevice == `PDC_UNLOCK_KEY |-> ##[1:2] statusFlags[11]) else $error("no unlock");
    chk_commit_store: assert property (storeStationWrite |-> selfReset &&
        {9'h000, storeStationData} == $past(parameterDataToDevice)) else $error("bad commit");
    // Motion gating
    chk_release_stop: assert property (!commandFlags[7] [*3] |->
        !motorForward && !motorReverse) else $error("runs without release");
    chk_error_stop: assert property (internalError [*3] |->
        statusFlags[11] && !motorForward && !motorReverse) else $error("error ignored");
    chk_jog_mirror: assert property (jogKeyUp [*6] |-> statusFlags[8])
        else $error("jog not mirrored");
    chk_run_clears: assert property ($rose(statusFlags[14]) && commandFlags[2]
        |-> ##[0:1] !statusFlags[4]) else $error("pos error kept");
endmodule : pdc_drive_control_props
bind pdc_drive_control pdc_drive_control_props pdc_drive_control_props_inst (
    .clock(clock), .reset(reset), .commandFlags(commandFlags), .parameterIndex(parameterIndex),
    .parameterDataToDevice(parameterDataToDevice), .cycleStrobe(cycleStrobe),
    .statusFlags(statusFlags), .readBackIndex(readBackIndex), .addressSelector(addressSelector),
    .stationNumber(stationNumber), .storedStationValid(storedStationValid),
    .storeStationWrite(storeStationWrite), .storeStationData(storeStationData),
    .selfReset(selfReset), .jogKeyUp(jogKeyUp), .internalError(internalError),
    .motorForward(motorForward), .motorReverse(motorReverse));
`default_nettype wire

// ===== test/pdc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_master_model (
    input wire logic clock,
    output logic cycleStrobe,
    output logic [7:0] parameterIndex,
    output logic [15:0] parameterDataToDevice
);
    // Idle frame contents
    initial begin
        cycleStrobe = 1'b0;
        parameterIndex = 8'h00;
        parameterDataToDevice = 16'h0000;
    end
    // One cyclic frame; index and data stay as levels afterwards
    task automatic frame(input logic [7:0] idx, input logic [15:0] dat);
        @(negedge clock);
        cycleStrobe = 1'b1;
        parameterIndex = idx;
        parameterDataToDevice = dat;
        @(negedge clock);
        cycleStrobe = 1'b0;
    endtask : frame
endmodule : pdc_master_model
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"
module tb_top;
    logic clock, reset, cycleStrobe, storedStationValid, jogKeyUp, jogKeyDown, internalError;
    logic storeStationWrite, storeRefWrite, selfReset, motorForward, motorReverse, motorManualSpeed;
    logic [15:0] commandFlags, statusFlags, parameterDataToDevice, parameterDataFromDevice;
    logic [31:0] targetPosition, actualPosition, encoderPosition, storeRefData;
    logic [7:0] parameterIndex, readBackIndex;
    logic [6:0] addressSelector, stationNumber, storedStation, storeStationData;
    logic revSeen, fwdSeen, manSeen, selfSeen;
    int errorCnt, nTests, seed, sel, prevPos, stSeen, refSeen, k;
    pdc_drive_control #(.PAUSE_UNIT_CYC(4)) pdc_drive_control_inst (.clock(clock), .reset(reset),
        .commandFlags(commandFlags), .targetPosition(targetPosition),
        .parameterIndex(parameterIndex), .parameterDataToDevice(parameterDataToDevice),
        .cycleStrobe(cycleStrobe), .statusFlags(statusFlags), .actualPosition(actualPosition),
        .parameterDataFromDevice(parameterDataFromDevice), .readBackIndex(readBackIndex),
        .addressSelector(addressSelector), .stationNumber(stationNumber),
        .storedStation(storedStation), .storedStationValid(storedStationValid),
        .storeStationWrite(storeStationWrite), .storeStationData(storeStationData),
        .storeRefWrite(storeRefWrite), .storeRefData(storeRefData), .selfReset(selfReset),
        .jogKeyUp(jogKeyUp), .jogKeyDown(jogKeyDown), .internalError(internalError),
        .encoderPosition(encoderPosition), .motorForward(motorForward),
        .motorReverse(motorReverse), .motorManualSpeed(motorManualSpeed));
    pdc_master_model pdc_master_model_inst (.clock(clock), .cycleStrobe(cycleStrobe),
        .parameterIndex(parameterIndex), .parameterDataToDevice(parameterDataToDevice));
    always #20 clock = ~clock;
    // Record pulses and motion directions
    always @(posedge clock) begin
        if (motorReverse === 1'b1) revSeen <= 1'b1;
        if (motorForward === 1'b1) fwdSeen <= 1'b1;
        if (motorManualSpeed === 1'b1) manSeen <= 1'b1;
        if (storeStationWrite === 1'b1) stSeen <= int'(storeStationData);
        if (storeRefWrite === 1'b1) refSeen <= int'(storeRefData);
        if (selfReset === 1'b1) selfSeen <= 1'b1;
    end
    task automatic endOfTest();
        $display("errors %0d checks %0d", errorCnt, nTests);
        if (errorCnt == 0 && nTests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : endOfTest
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    // Bounded wait for a status bit level
    task automatic waitLvl(input int b, input logic v);
        for (k = 0; k < 900 && statusFlags[b] !== v; k++) @(negedge clock);
        if (k == 900) begin
            errorCnt++;
            endOfTest();
        end
    endtask : waitLvl
    // Positioning run; model predicts end point, error flag, directions
    task automatic run(input int tgt, input int enc, input logic noLoop);
        @(negedge clock);
        targetPosition = tgt;
        encoderPosition = enc;
        commandFlags = noLoop ? 16'h00A4 : 16'h0084;
        revSeen = 1'b0;
        fwdSeen = 1'b0;
        waitLvl(14, 1'b1);
        waitLvl(14, 1'b0);
        tick(2);
        check(actualPosition, tgt);
        check(statusFlags[4], enc != tgt);
        check({revSeen, fwdSeen}, {tgt < prevPos, !(noLoop && tgt < prevPos)});
        prevPos = tgt;
    endtask : run
    task automatic holdUp(input int n);
        jogKeyUp = 1'b1;
        tick(n);
        jogKeyUp = 1'b0;
        tick(50);
    endtask : holdUp
    initial begin
        seed = 50;
        {clock, reset, storedStationValid, jogKeyUp, jogKeyDown, internalError} = 6'h10;
        {commandFlags, targetPosition, encoderPosition} = '0;
        {addressSelector, storedStation, errorCnt, nTests, prevPos} = '0;
        {revSeen, fwdSeen, manSeen, selfSeen, stSeen, refSeen} = '0;
        tick(4);
        reset = 1'b0;
        tick(2);
        check(stationNumber, 7'h64);
        storedStation = 7'h32;
        storedStationValid = 1'b1;
        for (int i = 0; i < 3; i++) begin
            sel = 1 + (($random(seed) & 32'h7FFF) % 99);
            addressSelector = 7'(sel);
            tick(4);
            check(stationNumber, sel);
        end
        addressSelector = 7'h00;
        run(20, 99, 1'b0);
        run(5, 5, 1'b0);
        run(2, 2, 1'b1);
        commandFlags = 16'h0088;
        targetPosition = 32'h0000_04D2;
        for (k = 0; k < 20 && refSeen == 0; k++) tick(1);
        tick(3);
        check(refSeen, 1234);
        check(actualPosition, 1234);
        commandFlags = 16'h0080;
        holdUp(8);
        check(actualPosition, 1234);
        commandFlags = 16'h00C0;
        holdUp(6);
        check(actualPosition, 1250);
        pdc_master_model_inst.frame(`PDC_IDX_JOG_PAUSE, 16'h0000);
        manSeen = 1'b0;
        holdUp(100);
        check(manSeen, 1'b0);
        check(actualPosition, 32'd1266);
        pdc_master_model_inst.frame(`PDC_IDX_JOG_PAUSE, 16'h0004);
        holdUp(100);
        check(manSeen, 1'b1);
        internalError = 1'b1;
        tick(5);
        check(statusFlags[11], 1'b1);
        internalError = 1'b0;
        commandFlags = 16'h0000;
        tick(4);
        check(statusFlags[11], 1'b0);
        commandFlags = 16'h0080;
        pdc_master_model_inst.frame(`PDC_IDX_UNLOCK, `PDC_UNLOCK_KEY);
        tick(2);
        check(statusFlags[11], 1'b1);
        pdc_master_model_inst.frame(`PDC_IDX_STATION, 16'h002A);
        tick(1);
        check({readBackIndex, parameterDataFromDevice}, {8'h34, 16'h0000});
        pdc_master_model_inst.frame(`PDC_IDX_COMMIT, 16'h002A);
        tick(4);
        check({selfSeen, parameterDataFromDevice}, {1'b1, 16'h0000});
        check(stSeen, 42);
        storedStation = 7'h2A;
        reset = 1'b1;
        tick(4);
        reset = 1'b0;
        tick(2);
        check(stationNumber, 7'h2A);
        endOfTest();
    end
endmodule : tb_top
`default_nettype wire
